// ---- hdl/drive_status_output_selector.v ----
// Status output selector and auxiliary contact input logic of a motor drive
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "drive_status_map.vh"

module drive_status_output_selector #(
   parameter ILIM_HOLD = `ILIM_HOLD_CYC, // Current limit hold in cycles
   parameter FW = 16 // Frequency and signal width
) (
   input wire clk, // 25 MHz control clock
   input wire rst_b, // Asynchronous reset, active low
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr, // Write address
   input wire s_axi_awvalid, // Write address valid
   output wire s_axi_awready, // Write address ready
   input wire [31:0] s_axi_wdata, // Write data
   input wire [3:0] s_axi_wstrb, // Write strobes
   input wire s_axi_wvalid, // Write data valid
   output wire s_axi_wready, // Write data ready
   output wire [1:0] s_axi_bresp, // Write response
   output wire s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   input wire [7:0] s_axi_araddr, // Read address
   input wire s_axi_arvalid, // Read address valid
   output wire s_axi_arready, // Read address ready
   output wire [31:0] s_axi_rdata, // Read data
   output wire [1:0] s_axi_rresp, // Read response
   output wire s_axi_rvalid, // Read data valid
   input wire s_axi_rready, // Read data ready
   // Pins
   input wire auxContactInput_b, // Aux input, low when closed to common
   input wire stopTerminal_b, // Stop terminal, low when closed
   output reg firstOcOutput, // First open-collector output, high sinks
   output reg secondOcOutput, // Second open-collector output
   output reg changeoverRelayContact, // Relay coil drive
   output reg secondRelayContact, // Optional second relay coil
   // Drive state from and to control logic
   input wire startCmd, // Start command pulse
   input wire stopCmd, // Stop command pulse
   input wire faultTrip, // Internal fault trip pulse
   input wire restartFail, // Failed automatic restart pulse
   input wire restartOk, // Successful restart pulse
   input wire inCurrentLimit, // Current limit active
   input wire autoMode, // Automatic reference mode
   input wire reverseSel, // Reverse rotation selected
   input wire closedLoop, // Closed-loop control active
   input wire sleepState, // Low-demand idle
   input wire followerIs4to20, // Follower is 4-20 mA
   input wire [FW-1:0] outFreq, // Output frequency, 0.01 Hz
   input wire [FW-1:0] actSpeed, // Actual speed, 0.01 Hz
   input wire [FW-1:0] speedSet, // Speed set point, 0.01 Hz
   input wire [FW-1:0] preset3, // Third preset, 0.01 Hz
   input wire [FW-1:0] loopRefUa, // Current-loop input, uA
   input wire [FW-1:0] feedback, // Process feedback
   input wire [FW-1:0] speedRef, // Speed reference signal
   input wire [FW-1:0] alarmLow, // Low alarm limit
   input wire [FW-1:0] alarmHigh, // High alarm limit
   output reg faultActive, // Drive is tripped
   output reg extFaultTrip, // External fault trip pulse
   output reg followerFaultTrip, // Follower fault trip pulse
   output reg usePreset4, // Run at fourth preset
   output reg useMinSpeed // Run at minimum speed
);
   ////////////////////////////////////////////////////////////////////////
   // Registers and bus state
   reg [31:0] ctrl_q;
   reg [31:0] outSel_q;
   reg awHeld_q;
   reg wHeld_q;
   reg [7:0] awAddr_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   reg bValid_q;
   reg [1:0] bResp_q;
   reg rValid_q;
   reg [31:0] rData_q;
   reg [1:0] rResp_q;
   reg aux1_q;
   reg aux2_q;
   reg stop1_q;
   reg stop2_q;
   reg auxPrev_q;
   reg stopPrev_q;
   reg running_q;
   reg lockout_q;
   reg [2:0] failCnt_q;
   reg atSpeed_q;
   reg ilim_q;
   reg [31:0] ilimCnt_q;
   reg followerLost_q;
   reg keypadStop_q;
   reg stopPending_q;

   wire doWrite = awHeld_q && wHeld_q && !bValid_q;
   wire [1:0] auxSel = ctrl_q[`CTRL_AUX_LSB +: 2];
   wire [1:0] lossSel = ctrl_q[`CTRL_LOSS_LSB +: 2];
   wire stopTermClears = ctrl_q[`CTRL_REMOTE_STOP_BIT];

   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready = !wHeld_q && !bValid_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = !rValid_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q <= 2'h0;
         rValid_q <= 1'b0;
         rData_q <= 32'h00000000;
         rResp_q <= 2'h0;
         ctrl_q <= `CTRL_RESET;
         outSel_q <= `OUTSEL_RESET;
         keypadStop_q <= 1'b0;
      end else begin
         keypadStop_q <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bValid_q <= 1'b1;
            bResp_q <= 2'h0;
            case (awAddr_q)
               `REG_CTRL: begin
                  ctrl_q <= merge(ctrl_q, wData_q, wStrb_q) & 32'h0000001f;
               end
               `REG_OUTSEL: begin
                  outSel_q <= merge(outSel_q, wData_q, wStrb_q) & 32'h001f1f1f;
               end
               `REG_STATUS: bResp_q <= 2'h0;
               `REG_CMD: begin
                  if (wStrb_q[0] && wData_q[`CMD_FACTORY_BIT]) begin
                     ctrl_q[`CTRL_AUX_LSB +: 2] <= `AUX_SEL_RESET;
                     outSel_q <= `OUTSEL_RESET;
                  end
                  keypadStop_q <= wStrb_q[0] && wData_q[`CMD_KEYPAD_STOP_BIT];
               end
               default: begin
                  bResp_q <= 2'h2;
               end
            endcase
         end else if (bValid_q && s_axi_bready) begin
            bValid_q <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            rValid_q <= 1'b1;
            rResp_q <= 2'h0;
            case (s_axi_araddr)
               `REG_CTRL: rData_q <= ctrl_q;
               `REG_OUTSEL: rData_q <= outSel_q;
               `REG_STATUS: rData_q <= {23'h0, failCnt_q, followerLost_q,
                  ilim_q, atSpeed_q, lockout_q, running_q, faultActive};
               `REG_CMD: rData_q <= 32'h00000000;
               default: begin
                  rData_q <= 32'h00000000;
                  rResp_q <= 2'h2;
               end
            endcase
         end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and contact edges
   wire auxClosed = !aux2_q;
   wire stopClosed = !stop2_q;
   wire auxCloseEdge = auxClosed && !auxPrev_q;
   wire stopCloseEdge = stopClosed && !stopPrev_q;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aux1_q <= 1'b1;
         aux2_q <= 1'b1;
         stop1_q <= 1'b1;
         stop2_q <= 1'b1;
         auxPrev_q <= 1'b0;
         stopPrev_q <= 1'b0;
      end else begin
         aux1_q <= auxContactInput_b;
         aux2_q <= aux1_q;
         stop1_q <= stopTerminal_b;
         stop2_q <= stop1_q;
         auxPrev_q <= auxClosed;
         stopPrev_q <= stopClosed;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Fault, trip and clear
   wire followerLow = loopRefUa < `FLWR_MIN_UA;
   wire followerLossEvt = followerIs4to20 && followerLow && !followerLost_q;
   reg extTrip;
   reg faultClear;
   always @* begin
      extTrip = 1'b0;
      case (auxSel)
         `AUX_TRIP_ON_CLOSE: extTrip = auxClosed;
         `AUX_TRIP_ON_OPEN: extTrip = !auxClosed;
         default: extTrip = 1'b0;
      endcase
      faultClear = keypadStop_q;
      if (auxSel == `AUX_CLEAR_ON_CLOSE) begin
         faultClear = faultClear || auxCloseEdge;
      end else if (stopTermClears) begin
         faultClear = faultClear || stopCloseEdge;
      end
   end

   wire lossTrip = followerLossEvt && lossSel == `LOSS_FAULT;
   wire anyTrip = faultTrip || (extTrip && !faultActive) || lossTrip;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         faultActive <= 1'b0;
         extFaultTrip <= 1'b0;
         followerFaultTrip <= 1'b0;
         followerLost_q <= 1'b0;
         usePreset4 <= 1'b0;
         useMinSpeed <= 1'b0;
      end else begin
         extFaultTrip <= extTrip && !faultActive;
         followerFaultTrip <= lossTrip;
         if (anyTrip) begin
            faultActive <= 1'b1; // Trip wins over clear
         end else if (faultClear) begin
            faultActive <= 1'b0;
         end
         followerLost_q <= followerIs4to20 && followerLow;
         usePreset4 <= followerIs4to20 && followerLow && lossSel == `LOSS_PRESET4;
         useMinSpeed <= followerIs4to20 && followerLow && lossSel == `LOSS_MINSPD;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Run, lockout, at-speed, current limit state
   localparam [31:0] BAND_FULL = `AT_SPEED_BAND_CHZ;
   wire [FW:0] band = BAND_FULL[FW:0]; // Band fits the speed width
   wire inBand = ({1'b0, actSpeed} + band >= {1'b0, speedSet}) &&
      ({1'b0, actSpeed} <= {1'b0, speedSet} + band);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         running_q <= 1'b0;
         lockout_q <= 1'b0;
         failCnt_q <= 3'h0;
         atSpeed_q <= 1'b0;
         ilim_q <= 1'b0;
         ilimCnt_q <= 32'h00000000;
         stopPending_q <= 1'b0;
      end else begin
         if (anyTrip) begin
            running_q <= 1'b0;
         end else if (startCmd) begin
            running_q <= 1'b1;
         end else if (stopPending_q && outFreq <= `RUN_STOP_CHZ) begin
            running_q <= 1'b0;
         end
         if (startCmd || anyTrip || !running_q) begin
            stopPending_q <= 1'b0;
         end else if (stopCmd) begin
            stopPending_q <= 1'b1;
         end
         if (restartFail && failCnt_q < `RESTART_LIMIT) begin
            failCnt_q <= failCnt_q + 3'h1;
         end else if (restartOk || (faultClear && !faultActive)) begin
            failCnt_q <= 3'h0;
         end
         lockout_q <= !(failCnt_q == `RESTART_LIMIT);
         if (actSpeed == speedSet) begin
            atSpeed_q <= 1'b1;
         end else if (!inBand) begin
            atSpeed_q <= 1'b0;
         end
         if (inCurrentLimit && !ilim_q) begin
            ilim_q <= 1'b1;
            ilimCnt_q <= 32'h00000000;
         end else if (ilim_q) begin
            if (ilimCnt_q < ILIM_HOLD - 1) begin
               ilimCnt_q <= ilimCnt_q + 32'h00000001;
            end else if (!inCurrentLimit) begin
               ilim_q <= 1'b0;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Indication selection
   wire [FW-1:0] alarmSig = closedLoop ? feedback : speedRef;
   wire lowAlarm = alarmSig < alarmLow;
   wire highAlarm = alarmSig > alarmHigh;
   wire inWindow = !lowAlarm && !highAlarm;

   function indicate;
      input [4:0] sel;
      input [18:0] st;
      begin
         case (sel)
            `IND_NONE: indicate = 1'b0;
            default: indicate = (sel <= `IND_ZERO) ? st[sel] : 1'b0;
         endcase
      end
   endfunction

   wire [18:0] stVec = {
      !running_q || outFreq == {FW{1'b0}} || sleepState || faultActive,
      sleepState,
      !highAlarm,
      highAlarm,
      !lowAlarm,
      lowAlarm,
      !inWindow,
      inWindow,
      reverseSel,
      !followerLow,
      autoMode,
      ilim_q,
      outFreq > preset3,
      atSpeed_q,
      lockout_q,
      faultActive,
      !faultActive,
      running_q,
      1'b0};

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         firstOcOutput <= 1'b0;
         secondOcOutput <= 1'b0;
         changeoverRelayContact <= 1'b0;
         secondRelayContact <= 1'b0;
      end else begin
         firstOcOutput <= indicate(outSel_q[`OUTSEL_OC1_LSB +: 5], stVec);
         secondOcOutput <= indicate(outSel_q[`OUTSEL_OC2_LSB +: 5], stVec);
         changeoverRelayContact <= indicate(outSel_q[`OUTSEL_RLY_LSB +: 5], stVec);
         secondRelayContact <= indicate(outSel_q[`OUTSEL_OC1_LSB +: 5], stVec);
      end
   end

endmodule

// ---- hdl/drive_status_map.vh ----
// Selection codes, register map and timing constants of the status selector
`ifndef DRIVE_STATUS_MAP_VH
`define DRIVE_STATUS_MAP_VH
// Auxiliary input function codes
`define AUX_TRIP_ON_CLOSE 2'h0
`define AUX_TRIP_ON_OPEN 2'h1
`define AUX_CLEAR_ON_CLOSE 2'h2
`define AUX_SEL_RESET 2'h0
// Output indication select codes
`define IND_NONE 5'h00
`define IND_RUN 5'h01
`define IND_FAULT 5'h02
`define IND_INV_FAULT 5'h03
`define IND_LOCK 5'h04
`define IND_AT_SPEED 5'h05
`define IND_ABOVE3 5'h06
`define IND_ILIMIT 5'h07
`define IND_AUTO 5'h08
`define IND_FLWR 5'h09
`define IND_REVERSE 5'h0a
`define IND_WIN 5'h0b
`define IND_INV_WIN 5'h0c
`define IND_LOW 5'h0d
`define IND_INV_LOW 5'h0e
`define IND_HIGH 5'h0f
`define IND_INV_HIGH 5'h10
`define IND_SLEEP 5'h11
`define IND_ZERO 5'h12
// Follower loss actions
`define LOSS_FAULT 2'h0
`define LOSS_PRESET4 2'h1
`define LOSS_MINSPD 2'h2
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_OUTSEL 8'h04
`define REG_STATUS 8'h08
`define REG_CMD 8'h0c
// CTRL fields
`define CTRL_AUX_LSB 0
`define CTRL_LOSS_LSB 2
`define CTRL_REMOTE_STOP_BIT 4
`define CTRL_RESET 32'h00000000
// OUTSEL fields
`define OUTSEL_OC1_LSB 0
`define OUTSEL_OC2_LSB 8
`define OUTSEL_RLY_LSB 16
`define OUTSEL_RESET 32'h00000000
// CMD bits (write one to act)
`define CMD_FACTORY_BIT 0
`define CMD_KEYPAD_STOP_BIT 1
// Timing
`define CLK_HZ 25000000
`define ILIM_HOLD_MS 500
`define ILIM_HOLD_CYC ((`CLK_HZ / 1000) * `ILIM_HOLD_MS)
`define RUN_STOP_CHZ 50
`define AT_SPEED_BAND_CHZ 50
`define FLWR_MIN_UA 2000
`define RESTART_LIMIT 3'h5
`endif

// ---- tb/drive_status_monitor.sv ----
// Concurrent checks on the status selector ports
`timescale 1ns/1ns
module drive_status_monitor (
   input wire clk, // Control clock
   input wire rst_b, // Reset, active low
   input wire faultTrip, // Trip pulse
   input wire followerIs4to20, // 4-20 mA follower in use
   input wire [15:0] loopRefUa, // Current-loop input
   input wire firstOcOutput, // First output
   input wire secondOcOutput, // Second output
   input wire changeoverRelayContact, // Relay
   input wire secondRelayContact, // Second relay
   input wire faultActive, // Drive tripped
   input wire extFaultTrip, // External trip
   input wire followerFaultTrip, // Follower trip
   input wire usePreset4, // Preset fallback
   input wire useMinSpeed // Minimum speed fallback
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   a_low_in_reset: assert property (@(posedge clk) disable iff (1'b0) !rst_b |->
      !(firstOcOutput || secondOcOutput || changeoverRelayContact || faultActive))
      else $error("output high during reset");
   a_relay_follows_first: assert property (secondRelayContact == firstOcOutput)
      else $error("second relay differs from first output");
   a_trip_sets_fault: assert property (faultTrip |-> ##[1:2] faultActive)
      else $error("trip did not set fault");
   a_ext_trip_faults: assert property (extFaultTrip |-> ##[0:2] faultActive)
      else $error("external trip did not set fault");
   a_flwr_trip_faults: assert property (followerFaultTrip |-> ##[0:2] faultActive)
      else $error("follower trip did not set fault");
   a_flwr_trip_cause: assert property ($rose(followerFaultTrip) |->
      $past(followerIs4to20) && $past(loopRefUa) < 16'h07d0)
      else $error("follower trip without loss");
   a_fallback_exclusive: assert property (!(usePreset4 && useMinSpeed))
      else $error("both fallbacks active");
   a_no_fallback_off: assert property ((!followerIs4to20) [*2] |->
      !usePreset4 && !useMinSpeed)
      else $error("fallback without 4-20 mA follower");
   a_preset_needs_loss: assert property ($rose(usePreset4) |-> $past(loopRefUa) < 16'h07d0)
      else $error("preset fallback with signal present");
endmodule
bind drive_status_output_selector drive_status_monitor i_mon (.clk(clk), .rst_b(rst_b),
   .faultTrip(faultTrip), .followerIs4to20(followerIs4to20), .loopRefUa(loopRefUa),
   .firstOcOutput(firstOcOutput), .secondOcOutput(secondOcOutput),
   .changeoverRelayContact(changeoverRelayContact), .secondRelayContact(secondRelayContact),
   .faultActive(faultActive), .extFaultTrip(extFaultTrip),
   .followerFaultTrip(followerFaultTrip), .usePreset4(usePreset4), .useMinSpeed(useMinSpeed));

// ---- tb/contact_model.sv ----
// Terminal strip contacts: aux contact and stop switch
`timescale 1ns/1ns
module contact_model (
   input wire closeAux, // Close aux contact to common
   input wire closeStop, // Close stop switch to common
   output wire auxContactInput_b, // Aux terminal level
   output wire stopTerminal_b // Stop terminal level
);
   // Open contact is pulled up, closed ties to common
   assign auxContactInput_b = closeAux ? 1'b0 : 1'b1;
   assign stopTerminal_b = closeStop ? 1'b0 : 1'b1;
endmodule

// ---- tb/tb_drive_status_output_selector.sv ----
// Self-checking bench for the status output selector
`timescale 1ns/1ns
`include "drive_status_map.vh"
module tb_drive_status_output_selector;
   logic clk = 0;
   logic rst_b = 1;
   logic [7:0] awAddr = 0, arAddr = 0;
   logic [31:0] wData = 0;
   logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
   wire awReady, wReady, bValid, arReady, rValid;
   wire [1:0] bResp, rResp;
   wire [31:0] rData;
   logic [4:0] pv = 0;
   logic [5:0] lv = 0;
   logic [15:0] outFreq = 0, actSpeed = 0, speedSet = 0, preset3 = 0, loopRefUa = 0;
   logic [15:0] feedback = 0, speedRef = 0, alarmLow = 0, alarmHigh = 0;
   logic [15:0] vals [4] = '{16'h0063, 16'h0064, 16'h00c8, 16'h00c9};
   logic closeAux = 0, closeStop = 0;
   wire auxIn_b, stopIn_b, oc1, oc2, rly, rly2, fAct, extTrip, flTrip, useP4, useMin;
   wire [2:0] o3 = {oc1, oc2, rly};
   int failures = 0;
   int comparisons = 0;
   always #20 clk = ~clk;
   drive_status_output_selector #(.ILIM_HOLD(20), .FW(16)) i_dut (
      .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .auxContactInput_b(auxIn_b), .stopTerminal_b(stopIn_b), .firstOcOutput(oc1),
      .secondOcOutput(oc2), .changeoverRelayContact(rly), .secondRelayContact(rly2),
      .startCmd(pv[0]), .stopCmd(pv[1]), .faultTrip(pv[2]), .restartFail(pv[3]),
      .restartOk(pv[4]), .inCurrentLimit(lv[0]), .autoMode(lv[1]), .reverseSel(lv[2]),
      .closedLoop(lv[3]), .sleepState(lv[4]), .followerIs4to20(lv[5]),
      .outFreq(outFreq), .actSpeed(actSpeed), .speedSet(speedSet), .preset3(preset3),
      .loopRefUa(loopRefUa), .feedback(feedback), .speedRef(speedRef),
      .alarmLow(alarmLow), .alarmHigh(alarmHigh), .faultActive(fAct),
      .extFaultTrip(extTrip), .followerFaultTrip(flTrip), .usePreset4(useP4),
      .useMinSpeed(useMin));
   contact_model i_contacts (.closeAux(closeAux), .closeStop(closeStop),
      .auxContactInput_b(auxIn_b), .stopTerminal_b(stopIn_b));
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task ck(input logic [31:0] a, input logic [31:0] e, input string m);
      comparisons++;
      if (a !== e) begin
         failures++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task st();
      repeat (6) @(negedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw;
      @(posedge clk);
      {awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'b111};
      ha = 0;
      hw = 0;
      while (!(ha && hw)) begin
         @(negedge clk);
         ha = ha | awReady;
         hw = hw | wReady;
         @(posedge clk);
         awValid <= !ha;
         wValid <= !hw;
      end
      while (bValid !== 1'b1) @(negedge clk);
      ck(bResp, 2'h0, "write response");
      @(posedge clk);
      bReady <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string m);
      @(posedge clk);
      {arAddr, arValid, rReady} <= {a, 2'b11};
      do @(negedge clk); while (arReady !== 1'b1);
      @(posedge clk);
      arValid <= 0;
      while (rValid !== 1'b1) @(negedge clk);
      ck(rResp, er, m);
      if (er == 2'h0) ck(rData, e, m);
      @(posedge clk);
      rReady <= 0;
   endtask
   task pulse(input logic [4:0] m);
      @(posedge clk) pv <= m;
      @(posedge clk) pv <= 0;
   endtask
   task sel(input logic [4:0] c);
      wr(`REG_OUTSEL, {11'h0, c, 3'h0, c, 3'h0, c});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs();
      rd(`REG_CTRL, `CTRL_RESET, 2'h0, "ctrl reset");
      rd(`REG_OUTSEL, `OUTSEL_RESET, 2'h0, "outsel reset");
      rd(8'h10, 0, 2'h2, "unmapped read");
   endtask
   task t_run();
      wr(`REG_OUTSEL, {11'h0, `IND_INV_FAULT, 3'h0, `IND_FAULT, 3'h0, `IND_RUN});
      pulse(5'h01);
      st();
      ck(o3, 3'b110, "run on start");
      @(posedge clk) outFreq <= 16'h0064;
      pulse(5'h02);
      st();
      ck(o3, 3'b110, "run while ramping");
      @(posedge clk) outFreq <= 16'h0032;
      st();
      ck(o3, 3'b010, "run off at low speed");
      pulse(5'h01);
      pulse(5'h04);
      st();
      ck(o3, 3'b001, "trip indications");
      wr(`REG_CMD, 32'h2);
      st();
      ck(o3, 3'b010, "keypad clear");
   endtask
   task t_aux();
      sel(`IND_INV_FAULT);
      @(posedge clk) closeAux <= 1;
      st();
      ck(fAct, 1, "close trips");
      wr(`REG_CTRL, 32'h1);
      wr(`REG_CMD, 32'h2);
      st();
      ck(fAct, 0, "closed no trip");
      @(posedge clk) closeAux <= 0;
      st();
      ck({fAct, o3}, 4'hf, "open trips");
      wr(`REG_CTRL, 32'h12);
      @(posedge clk) closeStop <= 1;
      st();
      ck(fAct, 1, "stop ignored");
      @(posedge clk) closeStop <= 0;
      @(posedge clk) closeAux <= 1;
      st();
      ck(fAct, 0, "contact clears");
      @(posedge clk) closeAux <= 0;
      wr(`REG_CTRL, 32'h10);
      pulse(5'h04);
      @(posedge clk) closeStop <= 1;
      st();
      ck(fAct, 0, "stop terminal clears");
      @(posedge clk) closeStop <= 0;
   endtask
   task t_ilim();
      sel(`IND_ILIMIT);
      @(posedge clk) lv[0] <= 1;
      @(posedge clk) lv[0] <= 0;
      repeat (12) @(negedge clk);
      ck(o3, 3'h7, "limit held");
      repeat (14) @(negedge clk);
      ck(o3, 3'h0, "limit released");
   endtask
   task lvt(input logic [4:0] c, input int b);
      sel(c);
      @(posedge clk) lv[b] <= 1;
      st();
      ck(o3, 3'h7, "level on");
      @(posedge clk) lv[b] <= 0;
      st();
      ck(o3, 3'h0, "level off");
   endtask
   task t_levels();
      lvt(`IND_AUTO, 1);
      lvt(`IND_REVERSE, 2);
      lvt(`IND_SLEEP, 4);
      @(posedge clk) lv[2] <= 1;
      sel(`IND_NONE);
      st();
      ck(o3, 3'h0, "disabled output");
      @(posedge clk) lv[2] <= 0;
   endtask
   task t_analog();
      sel(`IND_FLWR);
      @(posedge clk) loopRefUa <= 16'h07d1;
      st();
      ck(o3, 3'h7, "follower present");
      @(posedge clk) loopRefUa <= 16'h07cf;
      st();
      ck(o3, 3'h0, "follower absent");
      sel(`IND_ABOVE3);
      @(posedge clk) {preset3, outFreq} <= {16'h03e8, 16'h03e9};
      st();
      ck(o3, 3'h7, "above preset");
      @(posedge clk) outFreq <= 16'h03e7;
      st();
      ck(o3, 3'h0, "below preset");
      sel(`IND_AT_SPEED);
      @(posedge clk) {speedSet, actSpeed} <= {16'h03e8, 16'h03e8};
      st();
      @(posedge clk) actSpeed <= 16'h0419;
      st();
      ck(o3, 3'h7, "inside band");
      @(posedge clk) actSpeed <= 16'h0424;
      st();
      ck(o3, 3'h0, "outside band");
      @(posedge clk) actSpeed <= 16'h0419;
      st();
      ck(o3, 3'h0, "not yet at speed");
   endtask
   task t_alarm();
      logic lw, hi, e;
      @(posedge clk) {alarmLow, alarmHigh} <= {16'h0064, 16'h00c8};
      for (int m = 0; m < 2; m++) begin
         @(posedge clk) lv[3] <= m[0];
         for (int c = 11; c <= 16; c++) begin
            sel(c[4:0]);
            foreach (vals[i]) begin
               @(posedge clk) {feedback, speedRef} <=
                  m ? {vals[i], 16'h0096} : {16'h0096, vals[i]};
               lw = vals[i] < 16'h0064;
               hi = vals[i] > 16'h00c8;
               e = (c < 13) ? !(lw || hi) : (c < 15) ? lw : hi;
               e = e ^ !c[0];
               st();
               ck(o3, {3{e}}, "alarm level");
            end
         end
      end
   endtask
   task t_loss();
      wr(`REG_CTRL, 32'h4);
      @(posedge clk) {lv[5], loopRefUa} <= {1'b1, 16'h07cf};
      st();
      ck({useP4, useMin, fAct}, 3'b100, "preset fallback");
      wr(`REG_CTRL, 32'h8);
      st();
      ck({useP4, useMin, fAct}, 3'b010, "minimum speed fallback");
      @(posedge clk) loopRefUa <= 16'h07d1;
      wr(`REG_CTRL, 32'h0);
      @(posedge clk) loopRefUa <= 16'h07cf;
      st();
      ck({useP4, useMin, fAct}, 3'b001, "follower trip");
      @(posedge clk) loopRefUa <= 16'h07d1;
      wr(`REG_CMD, 32'h2);
      st();
      ck({useP4, useMin, fAct}, 3'b000, "follower back");
      @(posedge clk) lv[5] <= 0;
   endtask
   task t_lock();
      sel(`IND_LOCK);
      pulse(5'h04);
      repeat (4) pulse(5'h08);
      pulse(5'h10);
      repeat (4) pulse(5'h08);
      st();
      ck(o3, 3'h7, "fails not consecutive");
      pulse(5'h08);
      st();
      ck(o3, 3'h0, "lockout");
      wr(`REG_CMD, 32'h2);
   endtask
   task t_factory();
      wr(`REG_CTRL, 32'h1);
      sel(`IND_REVERSE);
      wr(`REG_CMD, 32'h1);
      rd(`REG_CTRL, 32'h0, 2'h0, "factory aux select");
      rd(`REG_OUTSEL, 32'h0, 2'h0, "factory output select");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b <= 0;
      repeat (4) @(posedge clk);
      rst_b <= 1;
      t_regs();
      t_run();
      t_aux();
      t_ilim();
      t_levels();
      t_analog();
      t_alarm();
      t_loss();
      t_lock();
      t_factory();
      end_sim();
   end
   initial begin
      #1000000;
      failures++;
      end_sim();
   end
endmodule
